// *** trace_bridge.sv ***
// Trace stream bridge package and top module with low-power handshake
`timescale 1ns/100ps
`default_nettype none

package trace_bridge_pkg;
    localparam int ID_W = 7;
    localparam int DATA_W = 32;
    localparam int BYTES_W = 2;
    localparam int BUF_DEPTH = 8;
    localparam logic ACK_RESET = 1'b1;
    localparam logic CACTIVE_LEVEL = 1'b0;

    // One trace beat as it travels through the buffer
    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [DATA_W-1:0] data;
        logic [BYTES_W-1:0] bytes;
    } beat_s;

    typedef enum logic [1:0] {LP_RUN, LP_FLUSH, LP_DRAIN, LP_SAFE} lp_state_e;
    typedef enum logic [1:0] {FL_IDLE, FL_FWD, FL_WAIT, FL_DONE} fl_state_e;
endpackage

module trace_bridge
    import trace_bridge_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic slv_rst_n,
    input wire logic mst_rst_n,
    input wire logic clkens,
    input wire logic clkenm,
    // Slave side trace input
    input wire logic atvalid_s,
    output logic atready_s,
    input wire beat_s beat_in,
    output logic afvalid_s,
    input wire logic afready_s,
    // Master side trace output
    output logic atvalid_m,
    input wire logic atready_m,
    output beat_s beat_out,
    input wire logic afvalid_m,
    output logic afready_m,
    // Low-power interface
    input wire logic csysreq,
    output logic csysack,
    output logic cactive
);
    localparam int CNT_W = $clog2(DEPTH) + 1;

    logic rst;
    logic discard;
    logic push_valid;
    logic push_ready;
    logic pop_ready;
    logic [CNT_W-1:0] fill;
    logic buf_empty;
    lp_state_e lp_ff, nxt_lp;
    fl_state_e fl_ff, nxt_fl;
    logic ack_ff, nxt_ack;

    // Any reset clears the whole crossing, so neither side sees stale entries
    assign rst = srst | ~slv_rst_n | ~mst_rst_n;
    assign buf_empty = (fill == '0);
    assign cactive = CACTIVE_LEVEL;
    assign csysack = ack_ff;

    // Trace is swallowed from the request onward
    assign discard = (lp_ff != LP_RUN);
    assign push_valid = atvalid_s & clkens & ~discard;
    assign atready_s = discard ? 1'b1 : push_ready;
    assign pop_ready = atready_m & clkenm;

    // Eight entries cover the enable round trip with room to spare
    trace_fifo #(
        .WIDTH($bits(beat_s)),
        .DEPTH(DEPTH)
    ) u_buf (
        .mclk(mclk),
        .rst(rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(beat_in),
        .out_valid(atvalid_m),
        .out_ready(pop_ready),
        .out_data(beat_out),
        .fill(fill)
    );

    // Slave-side flush request: forwarded master flush or low-power flush
    assign afvalid_s = (fl_ff == FL_FWD) | (lp_ff == LP_FLUSH);
    // Completion is withheld while anything sits in the buffer, even late arrivals
    assign afready_m = (fl_ff == FL_DONE) & clkenm & buf_empty;

    // Low-power sequence: flush upstream, drain, then hold safe
    always_comb begin
        nxt_lp = lp_ff;
        nxt_ack = ack_ff;
        case (lp_ff)
            LP_RUN: begin
                if (!csysreq) begin
                    nxt_lp = LP_FLUSH;
                end
            end
            LP_FLUSH: begin
                if (afready_s && clkens) begin
                    nxt_lp = LP_DRAIN;
                end
            end
            LP_DRAIN: begin
                // No master flush may be in flight when the sides part
                if (buf_empty && fl_ff == FL_IDLE) begin
                    nxt_lp = LP_SAFE;
                    nxt_ack = 1'b0;
                end
            end
            LP_SAFE: begin
                if (csysreq) begin
                    nxt_lp = LP_RUN;
                    nxt_ack = 1'b1;
                end
            end
            default: begin
                nxt_lp = LP_RUN;
                nxt_ack = ACK_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lp_ff <= LP_RUN;
            ack_ff <= ACK_RESET;
        end else begin
            lp_ff <= nxt_lp;
            ack_ff <= nxt_ack;
        end
    end

    // Master flush: forward upstream unless in low power, then wait empty
    always_comb begin
        nxt_fl = fl_ff;
        case (fl_ff)
            FL_IDLE: begin
                if (afvalid_m && clkenm) begin
                    nxt_fl = discard ? FL_WAIT : FL_FWD;
                end
            end
            FL_FWD: begin
                if (afready_s && clkens) begin
                    nxt_fl = FL_WAIT;
                end
            end
            FL_WAIT: begin
                if (buf_empty) begin
                    nxt_fl = FL_DONE;
                end
            end
            FL_DONE: begin
                // A beat pushed after the empty test sends us back to wait
                if (!buf_empty) begin
                    nxt_fl = FL_WAIT;
                end else if (clkenm) begin
                    nxt_fl = FL_IDLE;
                end
            end
            default: begin
                nxt_fl = FL_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fl_ff <= FL_IDLE;
        end else begin
            fl_ff <= nxt_fl;
        end
    end

    // Checks on the ports, the fill count and the two state machines
    a_cactive_low: assert property (@(posedge mclk) disable iff (rst)
        cactive == 1'b0) else $error("cactive driven high");
    a_flush_empty: assert property (@(posedge mclk) disable iff (rst)
        afready_m |-> fill == '0) else $error("flush done with data held");
    a_ack_safe: assert property (@(posedge mclk) disable iff (rst)
        $fell(csysack) |-> fill == '0 && !afvalid_s) else $error("ack before safe");
    a_lp_flush: assert property (@(posedge mclk) disable iff (rst)
        (lp_ff == LP_RUN && !csysreq) |=> afvalid_s) else $error("no flush on request");
    a_lp_discard: assert property (@(posedge mclk) disable iff (rst)
        (lp_ff != LP_RUN && atvalid_s) |-> atready_s ##1 (fill <= $past(fill)))
        else $error("trace stored in low power");
    a_no_forward: assert property (@(posedge mclk) disable iff (rst)
        (fl_ff == FL_IDLE && afvalid_m && clkenm && discard) |=> fl_ff == FL_WAIT)
        else $error("flush forwarded in low power");
    a_slave_enable: assert property (@(posedge mclk) disable iff (rst)
        !clkens |=> fill <= $past(fill)) else $error("push without slave enable");
    a_master_enable: assert property (@(posedge mclk) disable iff (rst)
        !clkenm |=> fill >= $past(fill)) else $error("pop without master enable");
    a_resume_ack: assert property (@(posedge mclk) disable iff (rst)
        (lp_ff == LP_SAFE && csysreq) |=> csysack && !discard) else $error("no resume");
endmodule

`default_nettype wire

// *** trace_fifo.sv ***
// Parameterised valid/ready FIFO used as the bridge's crossing buffer
`timescale 1ns/100ps
`default_nettype none

module trace_fifo #(
    parameter int WIDTH = 41,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] fill
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr;
    logic [AW-1:0] rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push;
    logic pop;

    // Full and empty come straight from the count, so back-pressure is exact
    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
    assign fill = cnt_ff;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and count update; wrap handles non power-of-two depths
    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset; entries are only read once written
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule

`default_nettype wire

// *** trace_partner.sv ***
// Model of the upstream flush responder and the downstream trace sink
`timescale 1ns/100ps
`default_nettype none
module trace_partner (
    input wire logic mclk,
    input wire logic afvalid_s,
    input wire logic stall,
    output logic afready_s,
    output logic atready_m
);
    int cnt = 0;
    // Upstream answers a flush late, as a busy source would
    initial afready_s = 1'b0;
    always @(negedge mclk) begin
        afready_s <= afvalid_s && cnt == 2;
        cnt <= (afvalid_s && cnt < 2) ? cnt + 1 : 0;
    end
    // Sink readiness is steered by the bench to make stalls
    assign atready_m = !stall;
endmodule
`default_nettype wire

// *** trace_bridge_tb_top.sv ***
// Self-checking bench for the trace bridge
`timescale 1ns/100ps
`default_nettype none
module trace_bridge_tb_top;
    import trace_bridge_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, clkens = 1'b1, clkenm = 1'b1, atvalid_s = 1'b0;
    logic afvalid_m = 1'b0, csysreq = 1'b1, stall = 1'b1;
    logic slv_rst_n = 1'b1, mst_rst_n = 1'b1;
    logic atready_s, afvalid_s, afready_s, atvalid_m, atready_m, afready_m, csysack, cactive;
    beat_s beat_in = '0, beat_out;
    int miscompares = 0, checks_done = 0, i;
    trace_bridge #(.DEPTH(8)) DUT (.mclk(mclk), .srst(srst), .slv_rst_n(slv_rst_n),
        .mst_rst_n(mst_rst_n), .clkens(clkens), .clkenm(clkenm), .atvalid_s(atvalid_s),
        .atready_s(atready_s), .beat_in(beat_in), .afvalid_s(afvalid_s), .afready_s(afready_s),
        .atvalid_m(atvalid_m), .atready_m(atready_m), .beat_out(beat_out),
        .afvalid_m(afvalid_m), .afready_m(afready_m), .csysreq(csysreq), .csysack(csysack),
        .cactive(cactive));
    trace_partner far_end (.mclk(mclk), .afvalid_s(afvalid_s), .stall(stall),
        .afready_s(afready_s), .atready_m(atready_m));
    // 25 MHz clock
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic give_verdict();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic beat_s bt(input int k);
        bt = {7'(k), 32'h00a5_0000 + 32'(k), 2'(k)};
    endfunction
    task automatic chk(input string n, input beat_s e, input beat_s s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // Flags share the beat compare, zero-extended so an unknown still shows
    task automatic chkb(input string n, input logic e, input logic s);
        chk(n, beat_s'({40'h0, e}), beat_s'({40'h0, s}));
    endtask
    // A wait that ran out of its bound ends the run
    task automatic tmo(input int k);
        if (k >= 60) begin
            miscompares++;
            give_verdict();
        end
    endtask
    // Valid is held until the edge where ready is high
    task automatic push(input int k);
        @(negedge mclk);
        atvalid_s = 1'b1;
        beat_in = bt(k);
        for (i = 0; i < 60 && atready_s !== 1'b1; i++) @(negedge mclk);
        tmo(i);
        @(negedge mclk);
        atvalid_s = 1'b0;
    endtask
    task automatic pop(input int k);
        for (i = 0; i < 60 && atvalid_m !== 1'b1; i++) @(negedge mclk);
        tmo(i);
        chk("beat_out", bt(k), beat_out);
        stall = 1'b0;
        @(negedge mclk);
        stall = 1'b1;
    endtask
    task automatic t_fill();
        for (int k = 0; k < 8; k++) push(k);
        chkb("atready_s full", 1'b0, atready_s);
        clkenm = 1'b0;
        stall = 1'b0;
        repeat (2) @(negedge mclk);
        stall = 1'b1;
        clkenm = 1'b1;
        for (int k = 0; k < 8; k++) pop(k);
        chkb("atvalid_m empty", 1'b0, atvalid_m);
    endtask
    task automatic t_ens();
        @(negedge mclk);
        clkens = 1'b0;
        atvalid_s = 1'b1;
        beat_in = bt(9);
        repeat (3) @(negedge mclk);
        atvalid_s = 1'b0;
        clkens = 1'b1;
        @(negedge mclk);
        chkb("atvalid_m gated", 1'b0, atvalid_m);
    endtask
    task automatic t_flush();
        push(20);
        push(21);
        afvalid_m = 1'b1;
        for (i = 0; i < 60 && afvalid_s !== 1'b1; i++) @(negedge mclk);
        tmo(i);
        repeat (6) @(negedge mclk);
        chkb("afready_m early", 1'b0, afready_m);
        pop(20);
        pop(21);
        for (i = 0; i < 60 && afready_m !== 1'b1; i++) @(negedge mclk);
        tmo(i);
        chkb("atvalid_m at done", 1'b0, atvalid_m);
        // Request stands through the edge that sees completion
        @(negedge mclk);
        chkb("afready_m pulse", 1'b0, afready_m);
        afvalid_m = 1'b0;
    endtask
    // Full buffer proves that accepted beats in low power are dropped
    task automatic t_lp();
        for (int k = 0; k < 8; k++) push(30 + k);
        csysreq = 1'b0;
        for (i = 0; i < 60 && afvalid_s !== 1'b1; i++) @(negedge mclk);
        tmo(i);
        push(50);
        chkb("atready_s discard", 1'b1, atready_s);
        chkb("csysack early", 1'b1, csysack);
        for (int k = 0; k < 8; k++) pop(30 + k);
        for (i = 0; i < 60 && csysack !== 1'b0; i++) @(negedge mclk);
        tmo(i);
        chkb("atvalid_m dropped", 1'b0, atvalid_m);
        afvalid_m = 1'b1;
        for (i = 0; i < 60 && afready_m !== 1'b1; i++) begin
            chkb("afvalid_s local", 1'b0, afvalid_s);
            @(negedge mclk);
        end
        tmo(i);
        @(negedge mclk);
        afvalid_m = 1'b0;
        chkb("cactive", CACTIVE_LEVEL, cactive);
        csysreq = 1'b1;
        repeat (2) @(negedge mclk);
        chkb("csysack", 1'b1, csysack);
        push(40);
        pop(40);
    endtask
    // Either side's reset mid-run empties the crossing and restores the handshake
    task automatic t_rst();
        for (int r = 0; r < 2; r++) begin
            push(60 + r);
            @(negedge mclk);
            slv_rst_n = (r != 0);
            mst_rst_n = (r == 0);
            repeat (2) @(negedge mclk);
            slv_rst_n = 1'b1;
            mst_rst_n = 1'b1;
            chkb("atvalid_m side reset", 1'b0, atvalid_m);
            chkb("csysack side reset", ACK_RESET, csysack);
        end
        push(62);
        pop(62);
    endtask
    // Reset for four cycles, then each scenario in turn
    initial begin
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        chkb("csysack reset", ACK_RESET, csysack);
        t_fill();
        t_ens();
        t_flush();
        t_lp();
        t_rst();
        give_verdict();
    end
endmodule
`default_nettype wire
